/* verilog/amc_acq_mode_ctrl.sv */
// Acquisition mode latches, conversion gating and status register
// Summary of operation
// [RULE1] Write 40h sets conversion disable if extended
// [RULE2] Write 00h clears conversion disable latch
// [RULE3] Disable write ignored without extended mode
// [RULE4] Conversion disable clears at reset, write only
// [RULE5] Disabled latch blocks every conversion clock
// [RULE6] DMA terminal count sets disable latch; code does so only in extended mode with single-cycle DMA
// [RULE7] Host clears latch after terminal count
// [RULE8] Host sets latches at setup, clears to acquire
// [RULE9] Burst latch clears at reset, write only
// [RULE10] Burst enable refused without extended mode
// [RULE11] Write 40h enables burst, 00h disables
// [RULE12] Extended mode latch clears at reset
// [RULE13] Extended mode register write only, 40h/00h
// [RULE14] Status read only, 0001 00XX after reset
// [RULE15] Status bits 7,3,2 zero; layout fixed
// [RULE16] Bit 0 shows clock select switch
// [RULE17] Bit 1 shows wait state switch
// [RULE18] Bit 4 high while conversions permitted
// [RULE19] Bit 5 high while extended mode set
// [RULE20] Bit 6 high while burst enabled
// [RULE21] Latches take state from data bit 6
`timescale 1ns/1ps
module amc_acq_mode_ctrl (
    // Clock, reset and clock enable
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    // Host I/O bus, synchronous to mclk
    input  wire amc_pkg::amc_addr_type ioAddr,
    input  wire amc_pkg::amc_byte_type ioWrData,
    input  wire logic                  ioWr,
    input  wire logic                  ioRd,
    output amc_pkg::amc_byte_type      ioRdData,
    output logic                       ioRdHit,
    // Board switches and DMA terminal count pins
    input  wire logic                  clkSelSwitch,
    input  wire logic                  waitStateSwitch,
    input  wire logic                  dmaTermCount,
    // Acquisition logic on mclk
    input  wire logic                  singleCycleDma,
    input  wire logic                  convClockReq,
    output logic                       convStart,
    output logic                       dmaAllowed,
    output logic                       burstActive,
    output logic                       extendedMode
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    amc_sync_if #(.WIDTH(amc_pkg::PIN_COUNT)) pinBus ();

    assign pinBus.raw[amc_pkg::PIN_CLK_SEL] = clkSelSwitch;
    assign pinBus.raw[amc_pkg::PIN_WAIT]    = waitStateSwitch;
    assign pinBus.raw[amc_pkg::PIN_DMA_TC]  = dmaTermCount;

    amc_sync_stage #(
        .WIDTH (amc_pkg::PIN_COUNT)
    ) pinSync (
        .mclk (mclk),
        .rstn (rstn),
        .ce   (ce),
        .pins (pinBus.stage)
    );

    logic clock_select_switch_flag;
    logic wait_state_switch_flag;
    logic tcLevel;
    logic tcLevelDelayed;
    logic tcEdge;

    assign clock_select_switch_flag = pinBus.synced[amc_pkg::PIN_CLK_SEL];
    assign wait_state_switch_flag   = pinBus.synced[amc_pkg::PIN_WAIT];
    assign tcLevel                  = pinBus.synced[amc_pkg::PIN_DMA_TC];

    // Edge detect runs on the synchronised level, never on the first stage
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tcLevelDelayed <= 1'b0;
        end else if (ce) begin
            tcLevelDelayed <= tcLevel;
        end
    end

    assign tcEdge = tcLevel & ~tcLevelDelayed;

    // ************************************************************
    // Write decode
    // ************************************************************
    logic wrConv;
    logic wrBurst;
    logic wrExt;
    logic rdStatus;
    logic wrValue;

    assign wrConv   = ioWr && (ioAddr == amc_pkg::CONV_DISABLE_OFS);
    assign wrBurst  = ioWr && (ioAddr == amc_pkg::BURST_MODE_OFS);
    assign wrExt    = ioWr && (ioAddr == amc_pkg::EXT_MODE_OFS);
    assign rdStatus = ioRd && (ioAddr == amc_pkg::STATUS_OFS);
    // Only bit 6 matters, so 40h sets and 00h clears
    assign wrValue  = ioWrData[amc_pkg::LATCH_DATA_BIT];  // see [RULE21]

    // ************************************************************
    // Mode latches
    // ************************************************************
    logic convDisable;
    logic tcStop;

    // Terminal count only acts in extended mode with single-cycle DMA
    assign tcStop = tcEdge && extendedMode && singleCycleDma;  // see [RULE6]

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            extendedMode <= amc_pkg::EXT_MODE_RST;  // see [RULE12]
        end else if (ce && wrExt) begin
            extendedMode <= wrValue;  // see [RULE13]
        end
    end

    // A terminal count in the same cycle as a clearing write wins
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            convDisable <= amc_pkg::CONV_DISABLE_RST;  // see [RULE4]
        end else if (ce) begin
            if (tcStop) begin
                convDisable <= 1'b1;  // see [RULE6]
            end else if (wrConv && wrValue && extendedMode) begin
                convDisable <= 1'b1;  // see [RULE1] [RULE3]
            end else if (wrConv && !wrValue) begin
                convDisable <= 1'b0;  // see [RULE2] [RULE7]
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            burstActive <= amc_pkg::BURST_RST;  // see [RULE9]
        end else if (ce && wrBurst) begin
            if (!wrValue) begin
                burstActive <= 1'b0;  // see [RULE11]
            end else if (extendedMode) begin
                burstActive <= 1'b1;  // see [RULE10] [RULE11]
            end
        end
    end

    // ************************************************************
    // Conversion gating
    // ************************************************************
    // Combinational so a request is gated in the cycle the latch sets
    assign convStart  = ce && convClockReq && !convDisable;  // see [RULE5]
    assign dmaAllowed = !convDisable;  // see [RULE6]

    // ************************************************************
    // Status read
    // ************************************************************
    amc_pkg::amc_byte_type statusWord;

    always_comb begin
        statusWord = '0;  // see [RULE15]
        statusWord[amc_pkg::STAT_CLK_SEL_BIT] =
            clock_select_switch_flag;  // see [RULE16]
        statusWord[amc_pkg::STAT_WAIT_BIT] =
            wait_state_switch_flag;  // see [RULE17]
        statusWord[amc_pkg::STAT_CONV_OK_BIT] =
            !convDisable;  // see [RULE18]
        statusWord[amc_pkg::STAT_EXT_MODE_BIT] =
            extendedMode;  // see [RULE19]
        statusWord[amc_pkg::STAT_BURST_BIT] =
            burstActive;  // see [RULE20]
    end

    logic conversions_allowed_flag;
    logic extended_mode_flag;
    logic burst_enabled_flag;

    assign conversions_allowed_flag = statusWord[amc_pkg::STAT_CONV_OK_BIT];
    assign extended_mode_flag       = statusWord[amc_pkg::STAT_EXT_MODE_BIT];
    assign burst_enabled_flag       = statusWord[amc_pkg::STAT_BURST_BIT];

    // Write-only offsets never answer a read: ioRdHit stays low and the data reads 00h
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ioRdData <= amc_pkg::STATUS_RST;  // see [RULE14]
            ioRdHit  <= 1'b0;
        end else if (ce) begin
            ioRdHit  <= rdStatus;  // see [RULE4] [RULE14]
            if (rdStatus) begin
                ioRdData <= statusWord;  // see [RULE16] [RULE17]
            end else begin
                ioRdData <= amc_pkg::READ_IDLE_VALUE;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence extSetWrite;
        ce && wrConv && wrValue && extendedMode;
    endsequence

    sequence tcArrives;
        ce && tcStop;
    endsequence

    convSet_a: assert property (  // see [RULE1]
        @(posedge mclk) disable iff (!rstn)
        extSetWrite |=> convDisable && !conversions_allowed_flag)
        else $error("conversion disable write did not set latch");

    convIgnore_a: assert property (  // see [RULE3]
        @(posedge mclk) disable iff (!rstn)
        ce && wrConv && wrValue && !extendedMode && !convDisable && !tcStop
        |=> !convDisable)
        else $error("disable accepted without extended mode");

    convClear_a: assert property (  // see [RULE2]
        @(posedge mclk) disable iff (!rstn)
        ce && wrConv && !wrValue && !tcStop |=> !convDisable ##0 dmaAllowed)
        else $error("clearing write left conversions disabled");

    convGate_a: assert property (  // see [RULE5]
        @(posedge mclk) disable iff (!rstn)
        convDisable |-> !convStart)
        else $error("conversion started while disabled");

    tcStop_a: assert property (  // see [RULE6]
        @(posedge mclk) disable iff (!rstn)
        tcArrives |=> convDisable ##0 !dmaAllowed)
        else $error("terminal count did not halt conversions");

    burstRefuse_a: assert property (  // see [RULE10]
        @(posedge mclk) disable iff (!rstn)
        ce && wrBurst && !extendedMode && !burstActive |=> !burstActive)
        else $error("burst enabled without extended mode");

    statusRead_a: assert property (  // see [RULE15]
        @(posedge mclk) disable iff (!rstn)
        ce && rdStatus |=> ioRdHit && ioRdData == {1'b0,
            $past(burst_enabled_flag), $past(extended_mode_flag),
            $past(conversions_allowed_flag), 2'b00,
            $past(wait_state_switch_flag), $past(clock_select_switch_flag)})
        else $error("status read data wrong");

    resetState_a: assert property (  // see [RULE12]
        @(posedge mclk) disable iff (!rstn)
        $rose(rstn) |-> !convDisable && !extendedMode && !burstActive
            && ioRdData == amc_pkg::STATUS_RST)
        else $error("latches not cleared after reset");

    // ************************************************************
    // Assertion sequences for writes, reads and frozen cycles
    // ************************************************************
    sequence extWrite;
        ce && wrExt;
    endsequence

    sequence burstSetWrite;
        ce && wrBurst && wrValue && extendedMode;
    endsequence

    sequence burstClearWrite;
        ce && wrBurst && !wrValue;
    endsequence

    sequence statusRead;
        ce && rdStatus;
    endsequence

    sequence otherCycle;
        ce && !rdStatus;
    endsequence

    sequence frozenCycle;
        !ce;
    endsequence

    extWrite_a: assert property (  // see [RULE13]
        @(posedge mclk) disable iff (!rstn)
        extWrite |=> extendedMode == $past(wrValue))
        else $error("extended mode write did not take data bit 6");

    burstSet_a: assert property (  // see [RULE11]
        @(posedge mclk) disable iff (!rstn)
        burstSetWrite |=> burstActive)
        else $error("burst enable write was not taken");

    burstClear_a: assert property (  // see [RULE11]
        @(posedge mclk) disable iff (!rstn)
        burstClearWrite |=> !burstActive)
        else $error("burst disable write was not taken");

    readIdle_a: assert property (  // see [RULE4]
        @(posedge mclk) disable iff (!rstn)
        otherCycle |=> !ioRdHit && ioRdData == amc_pkg::READ_IDLE_VALUE)
        else $error("read of a write-only offset answered");

    tcIgnore_a: assert property (  // see [RULE6]
        @(posedge mclk) disable iff (!rstn)
        ce && tcEdge && !singleCycleDma && !convDisable && !wrConv
        |=> !convDisable)
        else $error("terminal count acted without single-cycle DMA");

    freezeHold_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        frozenCycle |=> $stable(convDisable) && $stable(extendedMode)
            && $stable(burstActive) && $stable(ioRdData))
        else $error("state moved while clock enable was low");

    statusReserved_a: assert property (  // see [RULE15]
        @(posedge mclk) disable iff (!rstn)
        ioRdHit |-> !ioRdData[7] && ioRdData[3:2] == 2'b00)
        else $error("reserved status bits not zero");

    statusClock_a: assert property (  // see [RULE16]
        @(posedge mclk) disable iff (!rstn)
        statusRead |=> ioRdData[amc_pkg::STAT_CLK_SEL_BIT]
            == $past(clock_select_switch_flag))
        else $error("status clock select bit wrong");

    statusWait_a: assert property (  // see [RULE17]
        @(posedge mclk) disable iff (!rstn)
        statusRead |=> ioRdData[amc_pkg::STAT_WAIT_BIT]
            == $past(wait_state_switch_flag))
        else $error("status wait state bit wrong");

    statusConv_a: assert property (  // see [RULE18]
        @(posedge mclk) disable iff (!rstn)
        statusRead |=> ioRdData[amc_pkg::STAT_CONV_OK_BIT]
            == !$past(convDisable))
        else $error("status conversion permission bit wrong");

    statusExt_a: assert property (  // see [RULE19]
        @(posedge mclk) disable iff (!rstn)
        statusRead |=> ioRdData[amc_pkg::STAT_EXT_MODE_BIT]
            == $past(extendedMode))
        else $error("status extended mode bit wrong");

    statusBurst_a: assert property (  // see [RULE20]
        @(posedge mclk) disable iff (!rstn)
        statusRead |=> ioRdData[amc_pkg::STAT_BURST_BIT]
            == $past(burstActive))
        else $error("status burst bit wrong");

endmodule

/* verilog/amc_pkg.sv */
// Package of offsets, field positions and reset values for the mode block
package amc_pkg;

    // ************************************************************
    // Types
    // ************************************************************
    typedef logic [7:0] amc_byte_type;
    typedef logic [9:0] amc_addr_type;

    // ************************************************************
    // Register offsets on the host I/O space
    // ************************************************************
    localparam amc_addr_type CONV_DISABLE_OFS    = 10'h404;
    localparam amc_addr_type BURST_MODE_OFS      = 10'h405;
    localparam amc_addr_type EXT_MODE_OFS        = 10'h406;
    localparam amc_addr_type STATUS_OFS          = 10'h407;

    // ************************************************************
    // Written codes and the data bit that carries them
    // ************************************************************
    localparam amc_byte_type LATCH_SET_CODE      = 8'h40;
    localparam amc_byte_type LATCH_CLEAR_CODE    = 8'h00;
    localparam int           LATCH_DATA_BIT      = 6;

    // ************************************************************
    // Status field positions
    // ************************************************************
    localparam int           STAT_CLK_SEL_BIT    = 0;
    localparam int           STAT_WAIT_BIT       = 1;
    localparam int           STAT_CONV_OK_BIT    = 4;
    localparam int           STAT_EXT_MODE_BIT   = 5;
    localparam int           STAT_BURST_BIT      = 6;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic         CONV_DISABLE_RST    = 1'b0;
    localparam logic         EXT_MODE_RST        = 1'b0;
    localparam logic         BURST_RST           = 1'b0;
    localparam amc_byte_type STATUS_RST          = 8'h10;
    localparam amc_byte_type READ_IDLE_VALUE     = 8'h00;

    // ************************************************************
    // Synchroniser lanes for pin inputs
    // ************************************************************
    localparam int           PIN_COUNT           = 3;
    localparam int           PIN_CLK_SEL         = 0;
    localparam int           PIN_WAIT            = 1;
    localparam int           PIN_DMA_TC          = 2;
    localparam logic [2:0]   PIN_SYNC_RST        = 3'h0;

endpackage

/* verilog/amc_sync_if.sv */
// Interface carrying pin levels into and out of the synchroniser
`timescale 1ns/1ps
interface amc_sync_if #(
    parameter int WIDTH = 1
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    modport stage (input raw, output synced);
    modport user  (output raw, input synced);
endinterface

/* verilog/amc_sync_stage.sv */
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module amc_sync_stage #(
    parameter int WIDTH = 1
) (
    // Clock and control
    input wire logic  mclk,
    input wire logic  rstn,
    input wire logic  ce,
    // Pin levels in, synchronised levels out
    amc_sync_if.stage pins
);

    // First stage feeds the second stage and nothing else
    logic [WIDTH-1:0] firstStage;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            firstStage  <= '0;
            pins.synced <= '0;
        end else if (ce) begin
            firstStage  <= pins.raw;
            pins.synced <= firstStage;
        end
    end

endmodule

/* testbench/amc_dma_model.sv */
// Host DMA controller stand-in that pulses the terminal count pin
`timescale 1ns/1ps
module amc_dma_model (
    // Clock and request from the bench
    input  wire logic mclk,
    input  wire logic fire,
    input  wire logic slow,
    // Terminal count pin toward the board
    output logic      termCount
);
    int waitN;

    initial termCount = 1'b0;

    // Pin edges land mid-cycle, as the pin is not timed to the board clock
    always @(posedge mclk) begin
        if (fire) begin
            waitN = slow ? 5 : 0;
            repeat (waitN) @(posedge mclk);
            #7 termCount = 1'b1;
            repeat (2) @(posedge mclk);
            #7 termCount = 1'b0;
        end
    end
endmodule

/* testbench/test_acquisition_mode_control.sv */
// Self-checking bench for the acquisition mode latches and status
`timescale 1ns/1ps
module test_acquisition_mode_control;
    logic                  mclk, rstn, ce, ioWr, ioRd, ioRdHit, hit;
    logic                  clkSelSwitch, waitStateSwitch, dmaTermCount;
    logic                  singleCycleDma, convClockReq, convStart;
    logic                  dmaAllowed, burstActive, extendedMode;
    logic                  fire, slow, expExt, expCd, expBu;
    amc_pkg::amc_addr_type ioAddr;
    amc_pkg::amc_byte_type ioWrData, ioRdData, got, d;
    int                    badCount, cmpCount, cycles, seed, i;

    amc_acq_mode_ctrl u_amc_acq_mode_ctrl (.mclk(mclk), .rstn(rstn),
        .ce(ce), .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWr(ioWr),
        .ioRd(ioRd), .ioRdData(ioRdData), .ioRdHit(ioRdHit),
        .clkSelSwitch(clkSelSwitch), .waitStateSwitch(waitStateSwitch),
        .dmaTermCount(dmaTermCount), .singleCycleDma(singleCycleDma),
        .convClockReq(convClockReq), .convStart(convStart),
        .dmaAllowed(dmaAllowed), .burstActive(burstActive),
        .extendedMode(extendedMode));
    amc_dma_model u_amc_dma_model (.mclk(mclk), .fire(fire), .slow(slow),
        .termCount(dmaTermCount));

    // ****************************************
    // Clock, conversion requests and timeout
    // ****************************************
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        convClockReq <= 1'($random(seed));
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            finish_test();
        end
    end

    // ****************************************
    // Checks and expectations
    // ****************************************
    task automatic chk8(input string n, input amc_pkg::amc_byte_type e,
                        input amc_pkg::amc_byte_type s);
        cmpCount++;
        if (s !== e) begin
            badCount++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic s);
        cmpCount++;
        if (s !== e) begin
            badCount++;
            $display("BAD %s expected %b seen %b", n, e, s);
        end
    endtask
    function automatic amc_pkg::amc_byte_type exp_status();
        return {1'b0, expBu, expExt, ~expCd, 2'b00, waitStateSwitch,
                clkSelSwitch};
    endfunction
    task automatic chk_state();
        @(negedge mclk);
        chk1("dmaAllowed", ~expCd, dmaAllowed);
        chk1("convStart", convClockReq & ~expCd & ce,
             convStart);
        chk1("extendedMode", expExt, extendedMode);
        chk1("burstActive", expBu, burstActive);
    endtask

    // ****************************************
    // Host bus cycles
    // ****************************************
    task automatic wr(input amc_pkg::amc_addr_type a,
                      input amc_pkg::amc_byte_type v);
        @(posedge mclk);
        ioWr <= 1'b1;
        ioAddr <= a;
        ioWrData <= v;
        @(posedge mclk);
        ioWr <= 1'b0;
        case (a)
            amc_pkg::EXT_MODE_OFS: expExt = v[6];
            amc_pkg::CONV_DISABLE_OFS:
                expCd = v[6] ? (expCd | expExt) : 1'b0;
            amc_pkg::BURST_MODE_OFS:
                expBu = v[6] ? (expBu | expExt) : 1'b0;
            default: ;
        endcase
    endtask
    task automatic rd(input amc_pkg::amc_addr_type a);
        @(posedge mclk);
        ioRd <= 1'b1;
        ioAddr <= a;
        @(posedge mclk);
        ioRd <= 1'b0;
        @(negedge mclk);
        got = ioRdData;
        hit = ioRdHit;
    endtask
    task automatic pulse_tc(input logic s);
        @(posedge mclk);
        fire <= 1'b1;
        slow <= s;
        @(posedge mclk);
        fire <= 1'b0;
    endtask

    task automatic finish_test();
        if (badCount == 0 && cmpCount > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 84168;
        {mclk, rstn, ioWr, ioRd, fire, slow, singleCycleDma} = '0;
        {convClockReq, expExt, expCd, expBu} = '0;
        ce = 1'b1;
        ioAddr = '0;
        ioWrData = '0;
        clkSelSwitch = 1'($random(seed));
        waitStateSwitch = 1'($random(seed));
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
        chk_state();
        rd(amc_pkg::STATUS_OFS);
        chk8("statusReset", exp_status(), got);
        for (i = 0; i < 3; i++) begin
            rd(amc_pkg::CONV_DISABLE_OFS + 10'(i));
            chk8("writeOnlyData", amc_pkg::READ_IDLE_VALUE,
                 got);
            chk1("writeOnlyHit", 1'b0, hit);
        end
        wr(amc_pkg::CONV_DISABLE_OFS, amc_pkg::LATCH_SET_CODE);
        wr(amc_pkg::BURST_MODE_OFS, amc_pkg::LATCH_SET_CODE);
        chk_state();
        // Recommended setup: extended mode and disable set, then clear
        wr(amc_pkg::EXT_MODE_OFS, amc_pkg::LATCH_SET_CODE);
        wr(amc_pkg::CONV_DISABLE_OFS,
           amc_pkg::LATCH_SET_CODE);
        chk_state();
        wr(amc_pkg::BURST_MODE_OFS, amc_pkg::LATCH_SET_CODE);
        rd(amc_pkg::STATUS_OFS);
        chk8("statusSetup", exp_status(),
             got);
        wr(amc_pkg::CONV_DISABLE_OFS, amc_pkg::LATCH_CLEAR_CODE);
        wr(amc_pkg::BURST_MODE_OFS, amc_pkg::LATCH_CLEAR_CODE);
        chk_state();
        // Random sweep over mapped, read-only and unmapped offsets
        for (i = 0; i < 200; i++) begin
            @(posedge mclk);
            clkSelSwitch <= 1'($random(seed));
            waitStateSwitch <= 1'($random(seed));
            d = 8'($random(seed));
            wr(amc_pkg::CONV_DISABLE_OFS + 10'($random(seed) & 7), d);
            chk_state();
            rd(amc_pkg::STATUS_OFS);
            chk8("status", exp_status(),
                 got);
            chk1("statusHit", 1'b1, hit);
        end
        // Terminal count: ignored without single-cycle DMA, then taken
        wr(amc_pkg::EXT_MODE_OFS, amc_pkg::LATCH_SET_CODE);
        wr(amc_pkg::CONV_DISABLE_OFS, amc_pkg::LATCH_CLEAR_CODE);
        pulse_tc(1'b0);
        repeat (12) @(posedge mclk);
        chk_state();
        @(posedge mclk) singleCycleDma <= 1'b1;
        pulse_tc(1'b1);
        for (i = 0; i < 20 && dmaAllowed !== 1'b0; i++) @(posedge mclk);
        expCd = 1'b1;
        chk_state();
        wr(amc_pkg::BURST_MODE_OFS, amc_pkg::LATCH_CLEAR_CODE);
        chk_state();
        wr(amc_pkg::CONV_DISABLE_OFS,
           amc_pkg::LATCH_CLEAR_CODE);
        chk_state();
        // Clock enable low: the write is dropped and every latch holds
        @(posedge mclk) ce <= 1'b0;
        wr(amc_pkg::EXT_MODE_OFS, amc_pkg::LATCH_CLEAR_CODE);
        expExt = 1'b1;
        chk_state();
        @(posedge mclk) ce <= 1'b1;
        // Reset in mid-run drops every latch; switches return two cycles on
        wr(amc_pkg::BURST_MODE_OFS, amc_pkg::LATCH_SET_CODE);
        @(posedge mclk) rstn <= 1'b0;
        @(posedge mclk) rstn <= 1'b1;
        {expExt, expCd, expBu} = '0;
        chk_state();
        repeat (2) @(posedge mclk);
        rd(amc_pkg::STATUS_OFS);
        chk8("statusAfterReset", exp_status(), got);
        finish_test();
    end
endmodule
